// ==== rtl/occ_pkg.sv ====
`default_nettype none
package occ_pkg;
    // Data path and selection widths
    localparam int WORD_W = 24;
    localparam int BUS_W  = 32;
    localparam int ADDR_W = 8;
    localparam int SEL_N  = 4;

    // Register select positions
    localparam int SEL_P = 0;
    localparam int SEL_I = 1;
    localparam int SEL_B = 2;
    localparam int SEL_A = 3;
    localparam logic [SEL_N-1:0] SEL_RESET = 4'h1;
    localparam logic [SEL_N-1:0] SEL_ONE   = 4'h1;

    // Register offsets on the software port
    localparam logic [ADDR_W-1:0] ADDR_SWITCH_BANK = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_LAMPS       = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_DISPLAY     = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_MODE        = 8'h0c;

    // Protect trap vector and second branch location (octal 20 and 24)
    localparam logic [WORD_W-1:0] PROTECT_VECTOR = 24'h000010;
    localparam logic [WORD_W-1:0] PROTECT_ALT    = 24'h000014;

    // Indicator latches, lowest field in bit 0 when read
    typedef struct packed {
        logic autoMode;
        logic demand;
        logic stall;
        logic memParity;
        logic coreTemp;
        logic cabHeat;
        logic perBuf;
        logic overflow;
        logic stale;
        logic protect;
        logic watchdog;
    } lamps_type;
    localparam int LAMP_W = $bits(lamps_type);

    // Operator switches and buttons, sampled as levels
    typedef struct packed {
        logic [WORD_W-1:0] dispSw;
        logic [SEL_N-1:0]  selBtn;
        logic              clearBtn;
        logic              stepBtn;
        logic              demandBtn;
        logic              alarmClrBtn;
        logic              initBtn;
        logic              autoSw;
        logic              holdPSw;
        logic              holdISw;
        logic              stallLoSw;
        logic              intLoSw;
        logic              consoleLoSw;
        logic              parityStopSw;
    } consoleIn_type;

    // Processor register contents shown on the display
    typedef struct packed {
        logic [WORD_W-1:0] regA;
        logic [WORD_W-1:0] regB;
        logic [WORD_W-1:0] regI;
        logic [WORD_W-1:0] regP;
    } cpuRegs_type;

    // Processor events, one-cycle pulses except the heat1, heat2 and coreTempBad levels
    typedef struct packed {
        logic              wdExpire;
        logic              wdRestart;
        logic              protViol;
        logic              spbExec;
        logic [WORD_W-1:0] spbAddr;
        logic              longOpDone;
        logic              nextInstr;
        logic              ovfEvt;
        logic              jnoExec;
        logic              lprExec;
        logic              lprOvf;
        logic              perParity;
        logic              perDeadman;
        logic              heat1;
        logic              heat2;
        logic              stallTimeout;
        logic              coreTempBad;
        logic              memParityErr;
        logic              jndExec;
        logic              instrDone;
        logic              readSwitchOp;
    } cpuEvt_type;

    // Controls returned to the processor
    typedef struct packed {
        logic [WORD_W-1:0] setMask;
        logic              setA;
        logic              setB;
        logic              clrA;
        logic              clrB;
        logic              holdP;
        logic              holdI;
        logic              stallEnable;
        logic              stepPulse;
        logic              startTiming;
        logic              intMask;
        logic              protFetch;
        logic              shutdown;
        logic              halt;
        logic [WORD_W-1:0] switchWord;
        logic              switchValid;
    } cpuCtl_type;

    // Complete block state
    typedef struct packed {
        logic [WORD_W-1:0] prevDisp;
        logic [SEL_N-1:0]  prevSel;
        logic              prevClear;
        logic              prevStep;
        logic              prevDemand;
        logic              prevAlarm;
        logic              prevInit;
        logic [SEL_N-1:0]  sel;
        lamps_type         lamps;
        cpuCtl_type        ctl;
        logic [WORD_W-1:0] switchBank;
        logic [WORD_W-1:0] display;
        logic [BUS_W-1:0]  rdData;
    } state_type;
endpackage
`default_nettype wire

// ==== rtl/occ_console.sv ====
// Our own choices: the address map and the strobed register port.
`default_nettype none
module occ_console
    import occ_pkg::*;
(
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    // Operator panel
    input  wire consoleIn_type       conIn,
    output logic [WORD_W-1:0]        displayLamps,
    output logic [SEL_N-1:0]         selLamps,
    output lamps_type                lamps,
    output logic                     alarmLamp,
    // Processor side
    input  wire cpuRegs_type         cpuRegs,
    input  wire cpuEvt_type          cpuEvt,
    output cpuCtl_type               cpuCtl,
    output logic [WORD_W-1:0]        fetchAddr,
    // Software register port
    input  wire logic [ADDR_W-1:0]   busAddr,
    input  wire logic [BUS_W-1:0]    busWdata,
    input  wire logic                busWr,
    input  wire logic                busRd,
    output logic [BUS_W-1:0]         busRdata
);

    state_type          st_r;
    state_type          st_nxt;
    logic               consoleLock;
    logic               panelOn;
    logic               manualOn;
    logic [WORD_W-1:0]  dispRise;
    logic [SEL_N-1:0]   selRise;
    logic               clearRise;
    logic               stepRise;
    logic               demandFall;
    logic               alarmClr;
    logic               initRise;
    logic               spbHit;
    logic               parityFlag;

    // Panel qualifiers and button edges
    assign consoleLock = conIn.consoleLoSw;
    assign panelOn     = !consoleLock;
    assign manualOn    = panelOn && !st_r.lamps.autoMode;
    assign dispRise    = conIn.dispSw & ~st_r.prevDisp;
    assign selRise     = conIn.selBtn & ~st_r.prevSel;
    assign clearRise   = conIn.clearBtn && !st_r.prevClear;
    assign stepRise    = conIn.stepBtn && !st_r.prevStep;
    assign demandFall  = !conIn.demandBtn && st_r.prevDemand;
    assign alarmClr    = panelOn && conIn.alarmClrBtn && !st_r.prevAlarm;
    assign initRise    = manualOn && conIn.initBtn && !st_r.prevInit;
    assign spbHit      = cpuEvt.spbExec && (cpuEvt.spbAddr == PROTECT_VECTOR
                         || cpuEvt.spbAddr == PROTECT_ALT);
    assign parityFlag  = st_r.lamps.memParity || cpuEvt.memParityErr;

    // Next-state logic for the whole console
    always_comb begin
        st_nxt = st_r;
        st_nxt.prevDisp   = conIn.dispSw;
        st_nxt.prevSel    = conIn.selBtn;
        st_nxt.prevClear  = conIn.clearBtn;
        st_nxt.prevStep   = conIn.stepBtn;
        st_nxt.prevDemand = conIn.demandBtn;
        st_nxt.prevAlarm  = conIn.alarmClrBtn;
        st_nxt.prevInit   = conIn.initBtn;

        // Mode switch, frozen under console lockout
        if (panelOn) begin
            st_nxt.lamps.autoMode = conIn.autoSw;
        end
        st_nxt.ctl.startTiming = panelOn && conIn.autoSw
                                 && !st_r.lamps.autoMode;

        // Register select, lowest pressed button wins
        if (panelOn && (|selRise)) begin
            st_nxt.sel = selRise & (~selRise + SEL_ONE);
        end

        // Display entry and clear of A or B in manual mode
        st_nxt.ctl.setMask = manualOn ? dispRise : '0;
        st_nxt.ctl.setA = manualOn && st_r.sel[SEL_A] && (|dispRise);
        st_nxt.ctl.setB = manualOn && st_r.sel[SEL_B] && (|dispRise);
        st_nxt.ctl.clrA = manualOn && st_r.sel[SEL_A] && clearRise;
        st_nxt.ctl.clrB = manualOn && st_r.sel[SEL_B] && clearRise;

        // Panel switches routed to the processor
        st_nxt.ctl.holdP = panelOn && conIn.holdPSw;
        st_nxt.ctl.holdI = panelOn && conIn.holdISw;
        st_nxt.ctl.stallEnable = !(panelOn && st_r.lamps.autoMode
                                   && conIn.stallLoSw);
        st_nxt.ctl.intMask   = panelOn && conIn.intLoSw;
        st_nxt.ctl.stepPulse = manualOn && stepRise;

        // Switch bank word returned to the read-switch instruction
        st_nxt.ctl.switchValid = cpuEvt.readSwitchOp;
        if (cpuEvt.readSwitchOp) begin
            st_nxt.ctl.switchWord = st_r.switchBank;
        end

        // Selected register to the display lamps
        case (1'b1)
            st_r.sel[SEL_A]: st_nxt.display = cpuRegs.regA;
            st_r.sel[SEL_B]: st_nxt.display = cpuRegs.regB;
            st_r.sel[SEL_I]: st_nxt.display = cpuRegs.regI;
            default:         st_nxt.display = cpuRegs.regP;
        endcase

        // Watchdog lamp, expiry wins over restart
        if (cpuEvt.wdRestart) begin
            st_nxt.lamps.watchdog = 1'b0;
        end
        if (cpuEvt.wdExpire) begin
            st_nxt.lamps.watchdog = 1'b1;
        end

        // Memory protect lamp and trap request
        if (spbHit) begin
            st_nxt.lamps.protect = 1'b0;
        end
        if (cpuEvt.protViol) begin
            st_nxt.lamps.protect = 1'b1;
        end
        st_nxt.ctl.protFetch = cpuEvt.protViol;

        // Instruction register stale flag
        if (cpuEvt.nextInstr) begin
            st_nxt.lamps.stale = 1'b0;
        end
        if (cpuEvt.longOpDone) begin
            st_nxt.lamps.stale = 1'b1;
        end

        // Overflow flag with status restore
        if (cpuEvt.jnoExec || (cpuEvt.lprExec && !cpuEvt.lprOvf)) begin
            st_nxt.lamps.overflow = 1'b0;
        end
        if (cpuEvt.ovfEvt || (cpuEvt.lprExec && cpuEvt.lprOvf)) begin
            st_nxt.lamps.overflow = 1'b1;
        end

        // Latched errors cleared only by alarm/clear or initialize
        if (alarmClr) begin
            st_nxt.lamps.perBuf    = 1'b0;
            st_nxt.lamps.memParity = 1'b0;
            st_nxt.lamps.stall     = 1'b0;
        end
        if (cpuEvt.perParity || cpuEvt.perDeadman) begin
            st_nxt.lamps.perBuf = 1'b1;
        end
        if (cpuEvt.memParityErr) begin
            st_nxt.lamps.memParity = 1'b1;
        end
        if (cpuEvt.stallTimeout) begin
            st_nxt.lamps.stall = 1'b1;
        end

        // Temperature indicators follow their sensors
        st_nxt.lamps.cabHeat  = cpuEvt.heat1;
        st_nxt.lamps.coreTemp = cpuEvt.coreTempBad;

        // Shutdown on second heat limit, either heat limit with stall, or hot core with parity
        st_nxt.ctl.shutdown = cpuEvt.heat2
            || ((cpuEvt.heat1 || cpuEvt.heat2) && cpuEvt.stallTimeout)
            || (st_r.lamps.coreTemp && cpuEvt.memParityErr);

        // Demand flag set on release, even under lockout
        if (cpuEvt.jndExec) begin
            st_nxt.lamps.demand = 1'b0;
        end
        if (demandFall) begin
            st_nxt.lamps.demand = 1'b1;
        end

        // Parity stop halt held until the parity lamp is cleared
        st_nxt.ctl.halt = (st_r.ctl.halt && st_nxt.lamps.memParity)
            || (cpuEvt.instrDone && conIn.parityStopSw && parityFlag);

        // Initialize clears every indicator latch but the mode and temperature lamps
        if (initRise) begin
            st_nxt.lamps.watchdog  = 1'b0;
            st_nxt.lamps.protect   = 1'b0;
            st_nxt.lamps.stale     = 1'b0;
            st_nxt.lamps.overflow  = 1'b0;
            st_nxt.lamps.perBuf    = 1'b0;
            st_nxt.lamps.memParity = 1'b0;
            st_nxt.lamps.stall     = 1'b0;
            st_nxt.lamps.demand    = 1'b0;
            st_nxt.ctl.halt        = 1'b0;
        end

        // Software port: switch bank write and registered reads
        if (busWr && busAddr == ADDR_SWITCH_BANK) begin
            st_nxt.switchBank = busWdata[WORD_W-1:0];
        end
        st_nxt.rdData = '0;
        if (busRd) begin
            case (busAddr)
                ADDR_SWITCH_BANK: st_nxt.rdData = BUS_W'(st_r.switchBank);
                ADDR_LAMPS:       st_nxt.rdData = BUS_W'(st_r.lamps);
                ADDR_DISPLAY:     st_nxt.rdData = BUS_W'(st_r.display);
                ADDR_MODE:        st_nxt.rdData = BUS_W'({st_r.ctl.halt,
                                                          st_r.sel});
                default:          st_nxt.rdData = '0;
            endcase
        end
    end

    // State register with synchronous reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.sel <= SEL_RESET;
            st_r.ctl.stallEnable <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs from the state register, fetchAddr tied to PROTECT_VECTOR
    assign displayLamps = st_r.display;
    assign selLamps     = st_r.sel;
    assign lamps        = st_r.lamps;
    assign cpuCtl       = st_r.ctl;
    assign fetchAddr    = PROTECT_VECTOR;
    assign busRdata     = st_r.rdData;
    assign alarmLamp    = st_r.lamps.watchdog || st_r.lamps.protect
                          || st_r.lamps.perBuf || st_r.lamps.memParity
                          || st_r.lamps.stall || st_r.lamps.coreTemp
                          || st_r.lamps.cabHeat;

    // Checks on the console behaviour
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_setBit;
        cpuCtl.setA |-> $past(st_r.sel[SEL_A]) && $past(!st_r.lamps.autoMode)
                        && $past(!conIn.consoleLoSw) && (|cpuCtl.setMask);
    endproperty
    a_setBit: assert property (p_setBit)
        else $error("set of A outside manual select");

    property p_clearManual;
        (cpuCtl.clrA || cpuCtl.clrB) |-> $past(!st_r.lamps.autoMode);
    endproperty
    a_clearManual: assert property (p_clearManual)
        else $error("clear issued in automatic mode");

    property p_selOneHot;
        $onehot(selLamps);
    endproperty
    a_selOneHot: assert property (p_selOneHot)
        else $error("register select not one-hot");

    property p_stepManual;
        cpuCtl.stepPulse |-> $past(!st_r.lamps.autoMode)
                             && $past(!conIn.consoleLoSw) ##1 !cpuCtl.stepPulse;
    endproperty
    a_stepManual: assert property (p_stepManual)
        else $error("step pulse wrong mode or too long");

    property p_lockMode;
        conIn.consoleLoSw |=> $stable(st_r.lamps.autoMode);
    endproperty
    a_lockMode: assert property (p_lockMode)
        else $error("mode changed under console lockout");

    property p_watchdog;
        cpuEvt.wdExpire && !initRise |=> lamps.watchdog && alarmLamp;
    endproperty
    a_watchdog: assert property (p_watchdog)
        else $error("watchdog lamp not lit after expiry");

    property p_protect;
        cpuEvt.protViol && !initRise |=> lamps.protect && cpuCtl.protFetch
                                         && fetchAddr == PROTECT_VECTOR;
    endproperty
    a_protect: assert property (p_protect)
        else $error("protect violation not trapped");

    property p_perBufHold;
        lamps.perBuf && !$past(alarmClr) && !$past(initRise)
            |-> $past(lamps.perBuf) || $past(cpuEvt.perParity)
                || $past(cpuEvt.perDeadman);
    endproperty
    a_perBufHold: assert property (p_perBufHold)
        else $error("peripheral error lamp set without cause");

    property p_shutdown;
        cpuEvt.heat2 |=> cpuCtl.shutdown;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("no shutdown at second heat limit");

    property p_intMask;
        $past(rst_n) |-> cpuCtl.intMask
                         == $past(conIn.intLoSw && !conIn.consoleLoSw);
    endproperty
    a_intMask: assert property (p_intMask)
        else $error("interrupt mask does not follow lockout");

    property p_demand;
        cpuEvt.jndExec && !demandFall && !initRise |=> !lamps.demand;
    endproperty
    a_demand: assert property (p_demand)
        else $error("demand flag not cleared by jump");

    property p_haltHold;
        cpuCtl.halt && lamps.memParity && !alarmClr && !initRise
            |=> cpuCtl.halt;
    endproperty
    a_haltHold: assert property (p_haltHold)
        else $error("parity halt released while error stands");

    property p_switchWord;
        cpuEvt.readSwitchOp |=> cpuCtl.switchValid
                                && cpuCtl.switchWord == $past(st_r.switchBank);
    endproperty
    a_switchWord: assert property (p_switchWord)
        else $error("switch word not returned on read-switch");

    property p_stale;
        cpuEvt.longOpDone && !initRise |=> lamps.stale;
    endproperty
    a_stale: assert property (p_stale)
        else $error("stale flag not set after long operation");

    property p_overflow;
        cpuEvt.ovfEvt && !initRise |=> lamps.overflow;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow flag not set on overflow");

    property p_memParity;
        cpuEvt.memParityErr && !initRise |=> lamps.memParity && alarmLamp;
    endproperty
    a_memParity: assert property (p_memParity)
        else $error("parity lamp not lit after parity error");

    property p_stallLamp;
        cpuEvt.stallTimeout && !initRise |=> lamps.stall && alarmLamp;
    endproperty
    a_stallLamp: assert property (p_stallLamp)
        else $error("stall lamp not lit after stall timeout");

    property p_startTiming;
        cpuCtl.startTiming |-> lamps.autoMode && !$past(lamps.autoMode);
    endproperty
    a_startTiming: assert property (p_startTiming)
        else $error("timing start without manual to auto change");

endmodule // occ_console
`default_nettype wire

// ==== rtl/occ_placeholder_none.sv ====
`default_nettype none
`default_nettype wire

// ==== bench/occ_cpu_model.sv ====
`default_nettype none
module occ_cpu_model
    import occ_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Console controls and scripted events
    input  wire cpuCtl_type  ctl,
    input  wire cpuEvt_type  evtIn,
    // Register contents and events toward the console
    output cpuRegs_type      regs,
    output cpuEvt_type       evtOut
);
    timeunit 1ns;
    timeprecision 1ns;

    // Events come from the bench script unchanged
    assign evtOut = evtIn;

    // Registers obey set, clear, step and hold controls
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            regs <= '0;
        end else begin
            if (ctl.setA)
                regs.regA <= regs.regA | ctl.setMask;
            if (ctl.setB)
                regs.regB <= regs.regB | ctl.setMask;
            if (ctl.clrA)
                regs.regA <= '0;
            if (ctl.clrB)
                regs.regB <= '0;
            // A held register keeps its contents through a step
            if (ctl.stepPulse && !ctl.holdP)
                regs.regP <= regs.regP + 24'h000001;
            if (ctl.stepPulse && !ctl.holdI)
                regs.regI <= ~regs.regP;
        end
    end
endmodule // occ_cpu_model
`default_nettype wire

// ==== bench/tb_operator_console_control.sv ====
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    n_mismatch++; $display("wrong value at %0t: got %h expected %h", \
    $time, (g), (e)); end end
module tb_operator_console_control
    import occ_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // Clock, reset and bench state
    logic              sys_clk = 1'b0;
    logic              rst_n;
    consoleIn_type     conIn, sw, b;
    cpuEvt_type        evt, lvl, p, evtOut;
    cpuRegs_type       regs;
    cpuCtl_type        ctl;
    lamps_type         lamps, el;
    logic [WORD_W-1:0] displayLamps, fetchAddr, w;
    logic [WORD_W-1:0] expReg [SEL_N];
    logic [SEL_N-1:0]  selLamps;
    logic              alarmLamp, busWr, busRd;
    logic [ADDR_W-1:0] busAddr;
    logic [BUS_W-1:0]  busWdata, busRdata, rd;
    int                n_mismatch, n_compared, k;

    occ_console DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .conIn(conIn),
        .displayLamps(displayLamps), .selLamps(selLamps), .lamps(lamps),
        .alarmLamp(alarmLamp), .cpuRegs(regs), .cpuEvt(evtOut),
        .cpuCtl(ctl), .fetchAddr(fetchAddr), .busAddr(busAddr),
        .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
        .busRdata(busRdata)
    );

    occ_cpu_model uCpu (
        .sys_clk(sys_clk), .rst_n(rst_n), .ctl(ctl), .evtIn(evt),
        .regs(regs), .evtOut(evtOut)
    );

    // Free-running clock
    always #50 sys_clk = ~sys_clk;

    // Wait n edges, then settle at the falling edge
    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // Apply levels plus one-cycle buttons and events
    task automatic fire;
        @(posedge sys_clk);
        conIn <= sw | b;
        evt <= lvl | p;
        @(posedge sys_clk);
        conIn <= sw;
        evt <= lvl;
        b = '0;
        p = '0;
        @(negedge sys_clk);
    endtask

    // Register port write and read
    task automatic bw(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        busWr <= 1'b1;
        busAddr <= a;
        busWdata <= d;
        @(posedge sys_clk);
        busWr <= 1'b0;
    endtask
    task automatic br(input logic [7:0] a);
        @(posedge sys_clk);
        busRd <= 1'b1;
        busAddr <= a;
        @(posedge sys_clk);
        busRd <= 1'b0;
        @(negedge sys_clk);
        rd = busRdata;
    endtask

    // Lamps against the expected set
    task automatic chkL;
        `CHK(lamps, el)
        `CHK(alarmLamp, el.watchdog | el.protect | el.perBuf | el.memParity
            | el.stall | el.coreTemp | el.cabHeat)
    endtask

    task automatic give_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_mismatch++;
        give_verdict;
    end

    // Main sequence
    initial begin
        {conIn, sw, b, evt, lvl, p, el} = '0;
        {rst_n, busWr, busRd, busAddr, busWdata} = '0;
        {n_mismatch, n_compared} = '0;
        k = $urandom(32'hd92f6983);
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        tk(0);
        chkL;
        `CHK(selLamps, 4'h1)
        `CHK(ctl.stallEnable, 1'b1)
        // Switch bank, read-only and unmapped places
        w = 24'($urandom);
        bw(ADDR_SWITCH_BANK, {8'h00, w});
        br(ADDR_SWITCH_BANK);
        `CHK(rd, {8'h00, w})
        bw(ADDR_LAMPS, 32'hffffffff);
        br(ADDR_LAMPS);
        `CHK(rd, 32'h0)
        br(8'h30);
        `CHK(rd, 32'h0)
        p.readSwitchOp = 1'b1;
        fire;
        `CHK(ctl.switchValid, 1'b1)
        `CHK(ctl.switchWord, w)
        // Manual bit set into A then B
        expReg = '{default: '0};
        for (int r = SEL_A; r >= SEL_B; r--) begin
            b.selBtn = 4'(1 << r);
            fire;
            k = $urandom_range(23);
            b.dispSw[k] = 1'b1;
            fire;
            expReg[r] = 24'(1 << k);
            `CHK(ctl.setMask, expReg[r])
            `CHK({ctl.setA, ctl.setB}, (r == SEL_A) ? 2'b10 : 2'b01)
        end
        // Each select lights one lamp and shows its register
        for (int r = 0; r < SEL_N; r++) begin
            b.selBtn = 4'(1 << r);
            fire;
            `CHK(selLamps, 4'(1 << r))
            tk(1);
            `CHK(displayLamps, expReg[r])
        end
        br(ADDR_DISPLAY);
        `CHK(rd, {8'h00, expReg[SEL_A]})
        b.clearBtn = 1'b1;
        fire;
        `CHK({ctl.clrA, ctl.clrB}, 2'b10)
        tk(1);
        `CHK(regs.regA, 24'h0)
        b.stepBtn = 1'b1;
        fire;
        `CHK(ctl.stepPulse, 1'b1)
        {sw.holdPSw, sw.holdISw, sw.intLoSw} = 3'b111;
        fire;
        `CHK({ctl.holdP, ctl.holdI}, 2'b11)
        `CHK(ctl.intMask, 1'b1)
        // Automatic mode refuses manual functions
        {sw.holdPSw, sw.holdISw, sw.intLoSw} = 3'b000;
        sw.autoSw = 1'b1;
        sw.stallLoSw = 1'b1;
        fire;
        el.autoMode = 1'b1;
        `CHK(ctl.startTiming, 1'b1)
        chkL;
        tk(1);
        `CHK(ctl.stallEnable, 1'b0)
        b.stepBtn = 1'b1;
        b.clearBtn = 1'b1;
        b.dispSw[0] = 1'b1;
        fire;
        `CHK({ctl.stepPulse, ctl.clrA, ctl.setA}, 3'b000)
        b.selBtn = 4'h1;
        fire;
        `CHK(selLamps, 4'h1)
        // Console lockout keeps mode and select, passes demand
        sw.consoleLoSw = 1'b1;
        fire;
        sw.autoSw = 1'b0;
        b.selBtn = 4'h2;
        b.demandBtn = 1'b1;
        fire;
        tk(1);
        el.demand = 1'b1;
        chkL;
        `CHK(selLamps, 4'h1)
        `CHK(ctl.stallEnable, 1'b1)
        sw.consoleLoSw = 1'b0;
        fire;
        tk(1);
        el.autoMode = 1'b0;
        `CHK(ctl.stallEnable, 1'b1)
        p.jndExec = 1'b1;
        fire;
        el.demand = 1'b0;
        chkL;
        // Watchdog, stale and overflow indicators
        p.wdExpire = 1'b1;
        fire;
        el.watchdog = 1'b1;
        chkL;
        p.wdRestart = 1'b1;
        p.longOpDone = 1'b1;
        p.ovfEvt = 1'b1;
        fire;
        {el.watchdog, el.stale, el.overflow} = 3'b011;
        chkL;
        p.nextInstr = 1'b1;
        p.jnoExec = 1'b1;
        fire;
        {el.stale, el.overflow} = 2'b00;
        chkL;
        for (k = 1; k >= 0; k--) begin
            p.lprExec = 1'b1;
            p.lprOvf = k[0];
            fire;
            el.overflow = k[0];
            chkL;
        end
        // Protect trap and both clearing locations
        for (k = 0; k < 2; k++) begin
            p.protViol = 1'b1;
            fire;
            el.protect = 1'b1;
            chkL;
            `CHK({ctl.protFetch, fetchAddr}, {1'b1, 24'h000010})
            p.spbExec = 1'b1;
            p.spbAddr = 24'h000018;
            fire;
            chkL;
            p.spbExec = 1'b1;
            p.spbAddr = 24'(24'h000010 + 4 * k);
            fire;
            el.protect = 1'b0;
            chkL;
        end
        // Peripheral faults held until alarm/clear
        for (k = 0; k < 2; k++) begin
            {p.perParity, p.perDeadman} = (k == 0) ? 2'b10 : 2'b01;
            fire;
            el.perBuf = 1'b1;
            chkL;
            b.alarmClrBtn = 1'b1;
            fire;
            el.perBuf = 1'b0;
            chkL;
        end
        // Temperature limits and shutdown
        lvl.heat1 = 1'b1;
        fire;
        el.cabHeat = 1'b1;
        chkL;
        `CHK(ctl.shutdown, 1'b0)
        lvl.heat2 = 1'b1;
        fire;
        `CHK(ctl.shutdown, 1'b1)
        lvl.heat2 = 1'b0;
        p.stallTimeout = 1'b1;
        fire;
        el.stall = 1'b1;
        `CHK(ctl.shutdown, 1'b1)
        chkL;
        tk(1);
        `CHK(ctl.shutdown, 1'b0)
        lvl = '0;
        lvl.coreTempBad = 1'b1;
        fire;
        {el.cabHeat, el.coreTemp} = 2'b01;
        chkL;
        p.memParityErr = 1'b1;
        fire;
        el.memParity = 1'b1;
        `CHK(ctl.shutdown, 1'b1)
        chkL;
        lvl.coreTempBad = 1'b0;
        b.alarmClrBtn = 1'b1;
        fire;
        {el.coreTemp, el.memParity, el.stall} = 3'b000;
        chkL;
        // Parity stop halts until the error is cleared
        sw.parityStopSw = 1'b1;
        fire;
        p.memParityErr = 1'b1;
        p.instrDone = 1'b1;
        fire;
        tk(1);
        `CHK(ctl.halt, 1'b1)
        br(ADDR_MODE);
        `CHK(rd, 32'h00000011)
        b.alarmClrBtn = 1'b1;
        fire;
        tk(1);
        `CHK(ctl.halt, 1'b0)
        // Initialize clears the latched overflow and peripheral indicators
        p.ovfEvt = 1'b1;
        p.perParity = 1'b1;
        fire;
        b.initBtn = 1'b1;
        fire;
        el = '0;
        chkL;
        give_verdict;
    end
endmodule // tb_operator_console_control
`default_nettype wire
